// [asc_regs.svh]
// register offsets, field positions, reset values and timing counts of the serial port
// How it works
// - in 9-bit framing the ninth received bit reads in control three bit 7
// - data read ends flag clearing; software reads ninth bit before the data
// - a data write in 9-bit mode queues ninth transmit bit plus the byte
// - single-wire mode: control three bit 5 sets transmit pin direction
// - polarity invert bit 4 inverts every level driven on the transmit pin
// - overrun enable bit 3 requests an interrupt while overrun is set
// - noise enable bit 2 requests an interrupt while noise is set
// - framing enable bit 1 requests an interrupt while framing error is set
// - parity enable bit 0 requests an interrupt while parity error is set
// - data address reads the receive buffer and writes the transmit buffer
// - data reads and writes complete the automatic status flag clearing
// - transmitter and receiver run independently from one shared baud generator
// - baud generator divides the bus clock by a programmable modulo value
// - receiver realigns bit timing on a falling edge during the data bits, after the third sample
// - frame select gives 10-bit frames when 0 and 11-bit frames when 1
// - overrun clears only after status read with it set, then data read
// - polarity invert resets to 0 so the transmit pin idles high
`ifndef ASC_REGS_SVH
`define ASC_REGS_SVH

`define ASC_OFS_BAUD      8'h00
`define ASC_OFS_CTRL      8'h04
`define ASC_OFS_STATUS    8'h08
`define ASC_OFS_CTRL3     8'h0C
`define ASC_OFS_DATA      8'h10

`define ASC_BAUD_W        13
`define ASC_BAUD_RST      13'h001A

`define ASC_CTRL_FRAME9   0
`define ASC_CTRL_TXEN     1
`define ASC_CTRL_RXEN     2
`define ASC_CTRL_LOOP     3
`define ASC_CTRL_RECEIVER_SOURCE_SELECT     4
`define ASC_CTRL_PAREN    5
`define ASC_CTRL_PARODD   6
`define ASC_CTRL_MASK     7'h7F
`define ASC_CTRL_RST      7'h00

`define ASC_C3_RX9        7
`define ASC_C3_TX9        6
`define ASC_C3_DIR        5
`define ASC_C3_INV        4
`define ASC_C3_RST        8'h00
`define ASC_C3_WMASK      8'h7F

`define ASC_ST_TDRE       7
`define ASC_ST_TC         6
`define ASC_ST_RDRF       5
`define ASC_ST_OVR        3
`define ASC_ST_NF         2
`define ASC_ST_FE         1
`define ASC_ST_PF         0
`define ASC_ST_RST        8'hC0
`define ASC_ST_ERR_MASK   8'h0F
`define ASC_ST_RX_MASK    8'h2F
`define ASC_ST_TX_MASK    8'hC0

`define ASC_RT_LAST       4'hF
`define ASC_RT_S1         4'h2
`define ASC_RT_S2         4'h4
`define ASC_RT_S3         4'h6
`define ASC_RT_D1         4'h7
`define ASC_RT_D2         4'h8
`define ASC_RT_D3         4'h9
`define ASC_RT_RESYNC     4'h1
`define ASC_BITS_8        4'h8
`define ASC_BITS_9        4'h9
`define ASC_FRAME_10      4'hA
`define ASC_FRAME_11      4'hB

`endif

// [asc_pkg.sv]
// types of the asynchronous serial port
package asc_pkg;

    typedef enum logic [1:0] {
        ASC_RX_IDLE  = 2'b00,
        ASC_RX_START = 2'b01,
        ASC_RX_DATA  = 2'b10
    } asc_rx_state_t;

    typedef enum logic [0:0] {
        ASC_TX_IDLE  = 1'b0,
        ASC_TX_SHIFT = 1'b1
    } asc_tx_state_t;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [7:0]  address;
        logic [3:0]  byteenable;
        logic [31:0] writedata;
    } asc_avl_req_t;

    typedef struct packed {
        logic [31:0] readdata;
        logic        waitrequest;
    } asc_avl_rsp_t;

    typedef struct packed {
        logic o;
        logic oe;
    } asc_pin_out_t;

    typedef struct packed {
        logic [12:0] cnt;
        logic        tick;
    } asc_baud_state_t;

    typedef struct packed {
        asc_avl_rsp_t  bus;
        logic [12:0]   baud_div;
        logic [6:0]    ctrl;
        logic [7:0]    ctrl3;
        logic [7:0]    status;
        logic [7:0]    armed;
        logic [7:0]    tx_buf;
        logic          tx_buf9;
        logic          tx_full;
        asc_tx_state_t tx_state;
        logic [10:0]   tx_shift;
        logic [3:0]    tx_bits;
        logic [3:0]    tx_rt;
        asc_pin_out_t  txd;
        asc_rx_state_t rx_state;
        logic [3:0]    rx_rt;
        logic [3:0]    rx_bits;
        logic [8:0]    rx_shift;
        logic [1:0]    rx_samp;
        logic          rx_noise;
        logic [2:0]    rx_hist;
        logic          rx_prev;
        logic [7:0]    rx_buf;
        logic [1:0]    pin_s1;
        logic [1:0]    pin_s2;
        logic [1:0]    pin_s3;
        logic [1:0]    pin_filt;
        logic          err_irq;
    } asc_state_t;

endpackage : asc_pkg

// [asc_baud.sv]
// baud generator: bus clock divided by a modulo value into a 16x sample enable
module asc_baud (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic [12:0] divisor,
    output logic             tick16
);
    import asc_pkg::*;

    asc_baud_state_t st_reg;
    asc_baud_state_t st_next;

    // modulo counter, a divisor of zero stops the generator
    always_comb begin
        st_next = st_reg;
        st_next.tick = 1'b0;
        if (divisor == 13'h0000) begin
            st_next.cnt = 13'h0000;
        end else if (st_reg.cnt >= divisor - 13'h0001) begin
            st_next.cnt = 13'h0000;
            st_next.tick = 1'b1;
        end else begin
            st_next.cnt = st_reg.cnt + 13'h0001;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign tick16 = st_reg.tick;

endmodule : asc_baud

// [asc_top.sv]
// asynchronous serial port: register slave, transmitter, receiver
//
// Added by the designer: the register addresses and the Avalon-MM interface to the registers.
`include "asc_regs.svh"

module asc_top (
    input  wire logic          clk,
    input  wire logic          nrst,
    input  wire asc_pkg::asc_avl_req_t avl_req,
    output asc_pkg::asc_avl_rsp_t      avl_rsp,
    input  wire logic          rxd_i,
    input  wire logic          txd_i,
    output asc_pkg::asc_pin_out_t      txd,
    output logic               err_irq
);
    import asc_pkg::*;

    asc_state_t st_reg;
    asc_state_t st_next;
    logic       tick16;
    logic [1:0] filt_next;

    // one generator feeds both directions
    asc_baud u_baud (
        .clk     (clk),
        .nrst    (nrst),
        .divisor (st_reg.baud_div),
        .tick16  (tick16)
    );

    // a pin change counts once the second and third stages agree
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_filt
            assign filt_next[gi] = (st_reg.pin_s2[gi] == st_reg.pin_s3[gi]) ?
                                   st_reg.pin_s3[gi] : st_reg.pin_filt[gi];
        end
    endgenerate

    always_comb begin
        logic       req;
        logic       hit;
        logic       wr_ok;
        logic       frame9;
        logic       par_en;
        logic       par_odd;
        logic       single_wire;
        logic       rx_line;
        logic       bitv;
        logic       maj;
        logic [8:0] rx_word;
        logic [7:0] tx_data;
        logic       tx_b8;
        logic [3:0] ndata;
        logic       par_err;
        logic       stop_bad;

        st_next = st_reg;
        req = avl_req.read | avl_req.write;
        hit = req & ~st_reg.bus.waitrequest;
        wr_ok = hit & avl_req.write & avl_req.byteenable[0];
        frame9 = st_reg.ctrl[`ASC_CTRL_FRAME9];
        par_en = st_reg.ctrl[`ASC_CTRL_PAREN];
        par_odd = st_reg.ctrl[`ASC_CTRL_PARODD];
        single_wire = st_reg.ctrl[`ASC_CTRL_LOOP] & st_reg.ctrl[`ASC_CTRL_RECEIVER_SOURCE_SELECT];
        rx_line = 1'b1;
        bitv = 1'b0;
        maj = 1'b0;
        rx_word = 9'h000;
        tx_data = 8'h00;
        tx_b8 = 1'b0;
        par_err = 1'b0;
        stop_bad = 1'b0;
        ndata = frame9 ? `ASC_BITS_9 : `ASC_BITS_8;

        // pin synchronisers: bit 0 receive pin, bit 1 transmit pin in single-wire mode
        st_next.pin_s1 = {txd_i, rxd_i};
        st_next.pin_s2 = st_reg.pin_s1;
        st_next.pin_s3 = st_reg.pin_s2;
        st_next.pin_filt = filt_next;

        // receive source: pin, internal loop, or the shared transmit pin
        if (!st_reg.ctrl[`ASC_CTRL_LOOP]) begin
            rx_line = st_reg.pin_filt[0];
        end else if (single_wire) begin
            rx_line = st_reg.pin_filt[1];
        end else begin
            rx_line = st_reg.tx_shift[0] | (st_reg.tx_state == ASC_TX_IDLE);
        end

        // bus handshake: waitrequest drops for one cycle per request
        st_next.bus.waitrequest = ~(req & st_reg.bus.waitrequest);
        if (req && st_reg.bus.waitrequest && avl_req.read) begin
            if (avl_req.address == `ASC_OFS_BAUD) begin
                st_next.bus.readdata = {19'h00000, st_reg.baud_div};
            end else if (avl_req.address == `ASC_OFS_CTRL) begin
                st_next.bus.readdata = {25'h0000000, st_reg.ctrl};
            end else if (avl_req.address == `ASC_OFS_STATUS) begin
                st_next.bus.readdata = {24'h000000, st_reg.status};
            end else if (avl_req.address == `ASC_OFS_CTRL3) begin
                st_next.bus.readdata = {24'h000000, st_reg.ctrl3};
            end else if (avl_req.address == `ASC_OFS_DATA) begin
                st_next.bus.readdata = {24'h000000, st_reg.rx_buf};
            end else begin
                st_next.bus.readdata = 32'h00000000;
            end
        end

        // register writes and read side effects at the accepting edge
        if (wr_ok) begin
            if (avl_req.address == `ASC_OFS_BAUD) begin
                st_next.baud_div = avl_req.writedata[`ASC_BAUD_W-1:0];
            end else if (avl_req.address == `ASC_OFS_CTRL) begin
                st_next.ctrl = avl_req.writedata[6:0] & `ASC_CTRL_MASK;
            end else if (avl_req.address == `ASC_OFS_CTRL3) begin
                st_next.ctrl3 = (st_reg.ctrl3 & ~`ASC_C3_WMASK) |
                                (avl_req.writedata[7:0] & `ASC_C3_WMASK);
            end else if (avl_req.address == `ASC_OFS_DATA) begin
                st_next.tx_buf = avl_req.writedata[7:0];
                st_next.tx_buf9 = st_reg.ctrl3[`ASC_C3_TX9];
                st_next.tx_full = 1'b1;
                st_next.status = st_reg.status & ~(st_reg.armed & `ASC_ST_TX_MASK);
                st_next.armed = st_reg.armed & ~`ASC_ST_TX_MASK;
            end
        end
        if (hit && avl_req.read) begin
            if (avl_req.address == `ASC_OFS_STATUS) begin
                st_next.armed = st_reg.status;
            end else if (avl_req.address == `ASC_OFS_DATA) begin
                // flags armed by a status read clear now
                st_next.status = st_reg.status & ~(st_reg.armed & `ASC_ST_RX_MASK);
                st_next.armed = st_reg.armed & ~`ASC_ST_RX_MASK;
            end
        end

        // transmitter, one bit every sixteen sample enables
        if (st_reg.tx_state == ASC_TX_IDLE) begin
            st_next.tx_shift = 11'h7FF;
            if (tick16 && st_reg.ctrl[`ASC_CTRL_TXEN] && st_reg.tx_full) begin
                tx_data = st_reg.tx_buf;
                tx_b8 = st_reg.tx_buf9;
                if (par_en && frame9) begin
                    tx_b8 = (^tx_data) ^ par_odd;
                end else if (par_en) begin
                    tx_data[7] = (^tx_data[6:0]) ^ par_odd;
                end
                st_next.tx_shift = frame9 ? {1'b1, tx_b8, tx_data, 1'b0}
                                          : {2'b11, tx_data, 1'b0};
                st_next.tx_bits = frame9 ? `ASC_FRAME_11 : `ASC_FRAME_10;
                st_next.tx_rt = 4'h0;
                st_next.tx_full = wr_ok && (avl_req.address == `ASC_OFS_DATA);
                st_next.status[`ASC_ST_TDRE] = 1'b1;
                st_next.status[`ASC_ST_TC] = 1'b0;
                st_next.tx_state = ASC_TX_SHIFT;
            end
        end else if (tick16) begin
            st_next.tx_rt = st_reg.tx_rt + 4'h1;
            if (st_reg.tx_rt == `ASC_RT_LAST) begin
                st_next.tx_shift = {1'b1, st_reg.tx_shift[10:1]};
                st_next.tx_bits = st_reg.tx_bits - 4'h1;
                if (st_reg.tx_bits == 4'h1) begin
                    st_next.tx_state = ASC_TX_IDLE;
                    st_next.tx_shift = 11'h7FF;
                    if (!st_next.tx_full) begin
                        st_next.status[`ASC_ST_TC] = 1'b1;
                    end
                end
            end
        end

        // transmit pin: inversion covers every level driven
        st_next.txd.o = st_next.tx_shift[0] ^ st_reg.ctrl3[`ASC_C3_INV];
        if (single_wire) begin
            st_next.txd.oe = st_reg.ctrl3[`ASC_C3_DIR];
        end else begin
            st_next.txd.oe = st_reg.ctrl[`ASC_CTRL_TXEN] | (st_next.tx_state == ASC_TX_SHIFT);
        end

        // receiver, 16 samples per bit
        if (tick16) begin
            st_next.rx_prev = rx_line;
            case (st_reg.rx_state)
                ASC_RX_IDLE: begin
                    st_next.rx_hist = {st_reg.rx_hist[1:0], rx_line};
                    if (st_reg.ctrl[`ASC_CTRL_RXEN] && !rx_line && st_reg.rx_hist == 3'h7) begin
                        st_next.rx_state = ASC_RX_START;
                        st_next.rx_rt = 4'h1;
                        st_next.rx_noise = 1'b0;
                        st_next.rx_bits = 4'h0;
                        st_next.rx_samp = 2'h0;
                    end
                end
                ASC_RX_START: begin
                    st_next.rx_rt = st_reg.rx_rt + 4'h1;
                    if (st_reg.rx_rt == `ASC_RT_S1) begin
                        st_next.rx_samp[0] = rx_line;
                    end else if (st_reg.rx_rt == `ASC_RT_S2) begin
                        st_next.rx_samp[1] = rx_line;
                    end else if (st_reg.rx_rt == `ASC_RT_S3) begin
                        maj = (st_reg.rx_samp[0] & st_reg.rx_samp[1]) |
                              (rx_line & (st_reg.rx_samp[0] | st_reg.rx_samp[1]));
                        if (maj) begin
                            st_next.rx_state = ASC_RX_IDLE;
                            st_next.rx_hist = 3'h0;
                        end else if (st_reg.rx_samp != 2'h0 || rx_line) begin
                            st_next.rx_noise = 1'b1;
                        end
                    end else if (st_reg.rx_rt == `ASC_RT_LAST) begin
                        st_next.rx_state = ASC_RX_DATA;
                    end
                end
                ASC_RX_DATA: begin
                    st_next.rx_rt = st_reg.rx_rt + 4'h1;
                    if (st_reg.rx_prev && !rx_line && st_reg.rx_rt > `ASC_RT_D3) begin
                        st_next.rx_rt = `ASC_RT_RESYNC;
                        st_next.rx_bits = st_reg.rx_bits + 4'h1;
                    end else if (st_reg.rx_rt == `ASC_RT_D1) begin
                        st_next.rx_samp[0] = rx_line;
                    end else if (st_reg.rx_rt == `ASC_RT_D2) begin
                        st_next.rx_samp[1] = rx_line;
                    end else if (st_reg.rx_rt == `ASC_RT_LAST) begin
                        st_next.rx_bits = st_reg.rx_bits + 4'h1;
                    end else if (st_reg.rx_rt == `ASC_RT_D3) begin
                        bitv = (st_reg.rx_samp[0] & st_reg.rx_samp[1]) |
                               (rx_line & (st_reg.rx_samp[0] | st_reg.rx_samp[1]));
                        if (st_reg.rx_samp != {2{rx_line}}) begin
                            st_next.rx_noise = 1'b1;
                        end
                        if (st_reg.rx_bits < ndata) begin
                            st_next.rx_shift = {bitv, st_reg.rx_shift[8:1]};
                        end else begin
                            rx_word = frame9 ? st_reg.rx_shift : {1'b0, st_reg.rx_shift[8:1]};
                            par_err = par_en & ((^rx_word) != par_odd);
                            stop_bad = ~bitv;
                            st_next.rx_state = ASC_RX_IDLE;
                            st_next.rx_hist = (bitv || rx_word != 9'h000) ? 3'h7 : 3'h0;
                            if (st_next.status[`ASC_ST_RDRF]) begin
                                st_next.status[`ASC_ST_OVR] = 1'b1;
                            end else begin
                                st_next.rx_buf = rx_word[7:0];
                                st_next.ctrl3[`ASC_C3_RX9] = rx_word[8];
                                st_next.status[`ASC_ST_RDRF] = 1'b1;
                                st_next.status[`ASC_ST_NF] = st_next.rx_noise;
                                st_next.status[`ASC_ST_FE] = stop_bad;
                                st_next.status[`ASC_ST_PF] = par_err;
                            end
                        end
                    end
                end
                default: begin
                    st_next.rx_state = ASC_RX_IDLE;
                end
            endcase
        end
        if (!st_reg.ctrl[`ASC_CTRL_RXEN]) begin
            st_next.rx_state = ASC_RX_IDLE;
        end

        // error request level
        st_next.err_irq = |(st_next.status & st_next.ctrl3 & `ASC_ST_ERR_MASK);
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_reg <= '0;
            st_reg.bus.waitrequest <= 1'b1;
            st_reg.baud_div <= `ASC_BAUD_RST;
            st_reg.ctrl <= `ASC_CTRL_RST;
            st_reg.ctrl3 <= `ASC_C3_RST;
            st_reg.status <= `ASC_ST_RST;
            st_reg.tx_state <= ASC_TX_IDLE;
            st_reg.tx_shift <= 11'h7FF;
            st_reg.txd.o <= 1'b1;
            st_reg.rx_state <= ASC_RX_IDLE;
            st_reg.rx_prev <= 1'b1;
            st_reg.pin_s1 <= 2'h3;
            st_reg.pin_s2 <= 2'h3;
            st_reg.pin_s3 <= 2'h3;
            st_reg.pin_filt <= 2'h3;
        end else begin
            st_reg <= st_next;
        end
    end

    assign avl_rsp = st_reg.bus;
    assign txd = st_reg.txd;
    assign err_irq = st_reg.err_irq;

endmodule : asc_top

// [asc_top_chk.sv]
// checker of the bus handshake, transmit pin and error request of the serial port
module asc_top_chk (
    input wire logic                  clk,
    input wire logic                  nrst,
    input wire asc_pkg::asc_avl_req_t avl_req,
    input wire asc_pkg::asc_avl_rsp_t avl_rsp,
    input wire asc_pkg::asc_pin_out_t txd,
    input wire logic                  err_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    import asc_pkg::*;
    logic       ok;
    logic [7:0] c3_reg;
    logic [6:0] ctl_reg;
    logic       dw_reg;
    logic [3:0] q_reg;
    assign ok = avl_req.write && !avl_rsp.waitrequest && avl_req.byteenable[0];
    // shadows of control three, control and data writes; cycles since the last bus answer
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            c3_reg  <= 8'h00;
            ctl_reg <= 7'h00;
            dw_reg  <= 1'b0;
            q_reg   <= 4'h0;
        end else begin
            c3_reg  <= (ok && avl_req.address == 8'h0C) ? avl_req.writedata[7:0] : c3_reg;
            ctl_reg <= (ok && avl_req.address == 8'h04) ? avl_req.writedata[6:0] : ctl_reg;
            dw_reg  <= dw_reg || (ok && avl_req.address == 8'h10);
            q_reg   <= !avl_rsp.waitrequest ? 4'h0 : q_reg + {3'h0, q_reg != 4'hF};
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    a_wait_answer: assert property (
        (avl_req.read || avl_req.write) && avl_rsp.waitrequest |=> !avl_rsp.waitrequest)
        else $error("no answer one cycle after a request");
    a_wait_once: assert property (!avl_rsp.waitrequest |=> avl_rsp.waitrequest)
        else $error("answer longer than one cycle");
    a_c3_readback: assert property (
        avl_req.read && !avl_rsp.waitrequest && avl_req.address == 8'h0C
        |-> avl_rsp.readdata[6:0] == c3_reg[6:0])
        else $error("control three read differs from last write");
    a_irq_masked: assert property ((c3_reg[3:0] == 4'h0) [*3] |-> !err_irq)
        else $error("error request with all enables clear");
    a_irq_held: assert property ($fell(err_irq) |-> q_reg < 4'h4)
        else $error("error request dropped without a bus access");
    a_idle_high: assert property ((!dw_reg && !c3_reg[4]) [*3] |-> txd.o)
        else $error("idle transmit pin not high");
    a_idle_invert: assert property ((!dw_reg && c3_reg[4]) [*3] |-> !txd.o)
        else $error("inverted idle transmit pin not low");
    a_wire_input: assert property (
        (ctl_reg[4:3] == 2'b11 && !c3_reg[5]) [*3] |-> !txd.oe)
        else $error("single-wire pin driven while set as input");
    a_wire_output: assert property (
        (ctl_reg[4:3] == 2'b11 && c3_reg[5]) [*3] |-> txd.oe)
        else $error("single-wire pin not driven while set as output");
endmodule : asc_top_chk

bind asc_top asc_top_chk i_chk (.clk(clk), .nrst(nrst), .avl_req(avl_req),
    .avl_rsp(avl_rsp), .txd(txd), .err_irq(err_irq));

// [asc_peer.sv]
// remote serial device: sends frames on the receive pin, decodes the transmit pin
module asc_peer #(
    parameter int BIT_CLK = 32
) (
    input wire logic clk,
    input wire logic line,
    input wire logic inv,
    input wire logic nine,
    output logic     rxd
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [9:0] got_q[$];
    initial rxd = 1'b1;
    // start 0, data lsb first, ninth bit when nine is set, stop, then idle, each bit len clocks long
    task automatic send(input logic [8:0] d, input logic stop, input int len);
        logic [11:0] f;
        f = nine ? {1'b1, stop, d, 1'b0} : {2'b11, stop, d[7:0], 1'b0};
        for (int i = 0; i < 12; i++) begin
            rxd <= f[i];
            repeat (len) @(posedge clk);
        end
    endtask : send
    // a low level still low at mid start bit opens a frame; words hold stop and data
    initial begin
        logic [10:0] f;
        forever begin
            @(posedge clk);
            if ((line ^ inv) === 1'b0) begin
                f = '0;
                for (int i = 0; i < (nine ? 11 : 10) && !f[0]; i++) begin
                    repeat (i == 0 ? BIT_CLK / 2 : BIT_CLK) @(posedge clk);
                    f[i] = line ^ inv;
                end
                if (!f[0]) begin
                    got_q.push_back(nine ? f[10:1] : {f[9], 1'b0, f[8:1]});
                end
            end
        end
    end
endmodule : asc_peer

// [asc_top_bench.sv]
// self-checking bench of the serial port with a remote peer
module asc_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import asc_pkg::*;
    localparam int DIV = 2;
    logic         clk = 1'b0;
    logic         nrst = 1'b0;
    asc_avl_req_t req = '0;
    asc_avl_rsp_t rsp;
    asc_pin_out_t txd;
    logic         err_irq;
    logic         rxd;
    logic         pin;
    logic         pinv = 1'b0;
    logic         nine = 1'b0;
    logic [31:0]  q;
    logic [7:0]   d;
    int           t9;
    int           seed = 70710;
    int           err_total = 0;
    int           check_count = 0;
    always #2 clk = ~clk;
    assign pin = txd.oe ? txd.o : 1'b1;
    asc_top i_dut (.clk(clk), .nrst(nrst), .avl_req(req), .avl_rsp(rsp), .rxd_i(rxd),
        .txd_i(pin), .txd(txd), .err_irq(err_irq));
    asc_peer #(.BIT_CLK(DIV * 16)) i_peer (.clk(clk), .line(pin), .inv(pinv),
        .nine(nine), .rxd(rxd));
    task automatic print_verdict;
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one register access, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n = 0;
        @(posedge clk);
        req.read <= !wr;
        req.write <= wr;
        req.address <= a;
        req.byteenable <= 4'hF;
        req.writedata <= wd;
        do begin
            @(posedge clk);
            n++;
        end while (rsp.waitrequest !== 1'b0 && n < 50);
        if (n == 50) begin
            err_total++;
            print_verdict;
        end
        q = rsp.readdata;
        req.read <= 1'b0;
        req.write <= 1'b0;
    endtask : bus
    task automatic wait_st(input int b);
        int n = 0;
        do begin
            bus(1'b0, 8'h08, 0);
            n++;
        end while (q[b] !== 1'b1 && n < 1500);
        if (q[b] !== 1'b1) begin
            err_total++;
            print_verdict;
        end
    endtask : wait_st
    task automatic tx_chk(input logic [9:0] exp);
        int n = 0;
        while (i_peer.got_q.size() == 0 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        if (n == 3000) begin
            err_total++;
            print_verdict;
        end
        chk(i_peer.got_q.pop_front(), exp);
    endtask : tx_chk
    initial begin
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        bus(1'b0, 8'h0C, 0);
        chk(q, 32'h0);
        chk(txd.o, 1'b1);
        bus(1'b1, 8'h0C, 32'hFF);
        bus(1'b0, 8'h0C, 0);
        chk(q, 32'h7F);
        chk(txd.o, 1'b0);
        chk(err_irq, 1'b0);
        bus(1'b1, 8'h0C, 0);
        bus(1'b1, 8'h00, DIV);
        bus(1'b1, 8'h04, 7);
        nine = 1'b1;
        for (int k = 0; k < 4; k++) begin
            if (k != 1) begin
                t9 = (k != 2);
                bus(1'b1, 8'h0C, (t9 << 6) | ((k == 3) << 4));
                pinv = (k == 3);
            end
            d = $random(seed);
            bus(1'b1, 8'h10, {24'h0, d});
            tx_chk({1'b1, t9[0], d});
        end
        bus(1'b1, 8'h04, 6);
        nine = 1'b0;
        d = $random(seed);
        bus(1'b1, 8'h10, {24'h0, d});
        tx_chk({2'b10, d});
        bus(1'b1, 8'h04, 7);
        nine = 1'b1;
        i_peer.send(9'h15A, 1'b1, DIV * 16);
        wait_st(5);
        bus(1'b0, 8'h0C, 0);
        chk(q[7], 1'b1);
        bus(1'b0, 8'h10, 0);
        chk(q, 32'h5A);
        // remote sender about three percent fast, inside the allowed mismatch
        i_peer.send(9'h0AA, 1'b1, DIV * 16 - 1);
        wait_st(5);
        chk(q[3:0], 4'h0);
        bus(1'b0, 8'h10, 0);
        chk(q, 32'hAA);
        i_peer.send(9'h0F0, 1'b0, DIV * 16);
        i_peer.send(9'h033, 1'b1, DIV * 16);
        wait_st(3);
        chk(q[3:0], 4'hA);
        pinv = 1'b0;
        for (int en = 0; en < 16; en++) begin
            bus(1'b1, 8'h0C, en);
            bus(1'b0, 8'h0C, 0);
            chk(q, en);
            chk(err_irq, (en & 10) != 0);
        end
        bus(1'b0, 8'h08, 0);
        bus(1'b0, 8'h10, 0);
        chk(q, 32'hF0);
        bus(1'b0, 8'h08, 0);
        chk({q[5], q[3:0]}, 5'h00);
        chk(err_irq, 1'b0);
        // internal loop with parity; receiver restarted first
        bus(1'b1, 8'h04, 32'h2B);
        bus(1'b1, 8'h04, 32'h2F);
        d = $random(seed);
        bus(1'b1, 8'h10, {24'h0, d});
        tx_chk({1'b1, ^d, d});
        wait_st(5);
        chk(q[3:0], 4'h0);
        bus(1'b0, 8'h10, 0);
        chk(q, {24'h0, d});
        bus(1'b1, 8'h04, 32'h1E);
        bus(1'b1, 8'h0C, 32'h20);
        bus(1'b0, 8'h0C, 0);
        chk(txd.oe, 1'b1);
        bus(1'b1, 8'h0C, 0);
        bus(1'b0, 8'h0C, 0);
        chk(txd.oe, 1'b0);
        print_verdict;
    end
endmodule : asc_top_bench
